/* File: logic/dst_pkg.sv */
// constants and register map for the dual synchronous timer pair
// What this block does
// (RL1) internal, gated or external clock per timer
// (RL2) timers join into one 32-bit timer
// (RL3) wide mode: control from A, flag via B
// (RL4) only timer B drives the converter trigger
// (RL5) software never writes period zero or one
// (RL6) clear, set, invert aliases at plus 4/8/c
// (RL7) enable bit 15 starts and halts timer
// (RL8) stop-in-idle bit 13 halts during idle
// (RL9) gate bit 7 works only with internal clock
// (RL10) prescale field bits 6..4 selects divide ratio
// (RL11) timer A source bit picks its pin
// (RL12) timer B source bit picks its pin
// (RL13) wide mode ignores timer B settings
// (RL14) software clears B stop-in-idle for wide idle
// (RL15) software skips access right after disable
// (RL16) wide select only in A; B bit 3 zero
// (RL17) unimplemented bits read zero, ignore writes
// (RL18) reset: control, count zero; period all ones
// (RL19) count wraps at period, raising flag
// (RL20) pins synchronised; gated counts while gate high
package dst_pkg;
  localparam logic [15:0] DST_A_CTRL_OFS = 16'h8040;
  localparam logic [15:0] DST_A_CNT_OFS = 16'h8050;
  localparam logic [15:0] DST_A_PER_OFS = 16'h8060;
  localparam logic [15:0] DST_B_CTRL_OFS = 16'h8080;
  localparam logic [15:0] DST_B_CNT_OFS = 16'h8090;
  localparam logic [15:0] DST_B_PER_OFS = 16'h80a0;
  // status register of flags, write one to clear
  localparam logic [15:0] DST_STAT_OFS = 16'h80c0;
  localparam logic [3:0] DST_ALIAS_CLR = 4'h4;
  localparam logic [3:0] DST_ALIAS_SET = 4'h8;
  localparam logic [3:0] DST_ALIAS_INV = 4'hc;
  localparam int DST_ON_BIT = 15;
  localparam int DST_STOP_IN_IDLE_BIT = 13;
  localparam int DST_GATE_BIT = 7;
  localparam int DST_PS_LSB = 4;
  localparam int DST_WIDE_BIT = 3;
  localparam int DST_CS_BIT = 1;
  localparam logic [15:0] DST_CTRL_A_MASK = 16'ha0fa;
  localparam logic [15:0] DST_CTRL_B_MASK = 16'ha0f2;
  localparam logic [15:0] DST_CTRL_RST = 16'h0000;
  localparam logic [15:0] DST_CNT_RST = 16'h0000;
  localparam logic [15:0] DST_PER_RST = 16'hffff;
  localparam logic [1:0] DST_RESP_OKAY = 2'b00;
  localparam logic [1:0] DST_RESP_SLVERR = 2'b10;
endpackage : dst_pkg

/* File: logic/dst_timer_pair.sv */
// dual 16-bit timer pair with 32-bit join and axi4-lite registers
`timescale 1ns/10ps
module dst_timer_pair #(
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic idle_mode,
  input wire logic timer_a_ext_clock_pin,
  input wire logic timer_b_ext_clock_pin,
  input wire logic timer_a_gate_pin,
  input wire logic timer_b_gate_pin,
  output logic timer_a_flag,
  output logic timer_b_flag,
  output logic adc_trigger
);

  // ----------------------------------------------------------------
  // registers and pin synchronisers
  // ----------------------------------------------------------------
  logic [15:0] ctrl_ff [2];
  logic [15:0] cnt_ff [2];
  logic [15:0] per_ff [2];
  logic [1:0] flag_ff;
  logic adc_trig_ff;
  logic [1:0] ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic [1:0] gate_s1_ff, gate_s2_ff;
  logic idle_s1_ff, idle_s2_ff;
  logic [7:0] pre_ff [2];
  logic wide;
  logic [1:0] tick;
  logic [1:0] wrap;
  logic [31:0] cnt32;
  logic [31:0] per32;
  logic [31:0] cnt32_inc;

  // (RL20) two-stage pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_ff <= 2'b00;
      ext_s2_ff <= 2'b00;
      ext_s3_ff <= 2'b00;
      gate_s1_ff <= 2'b00;
      gate_s2_ff <= 2'b00;
      idle_s1_ff <= 1'b0;
      idle_s2_ff <= 1'b0;
    end else begin
      ext_s1_ff <= {timer_b_ext_clock_pin, timer_a_ext_clock_pin};
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      gate_s1_ff <= {timer_b_gate_pin, timer_a_gate_pin};
      gate_s2_ff <= gate_s1_ff;
      idle_s1_ff <= idle_mode;
      idle_s2_ff <= idle_s1_ff;
    end
  end

  // (RL3) wide select lives only in timer A
  assign wide = ctrl_ff[0][dst_pkg::DST_WIDE_BIT];

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic aw_hold_ff, w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_wr;
  logic [15:0] wa;
  logic [15:0] wbase;
  logic [3:0] walias;
  logic [15:0] wval;
  logic [15:0] rbase;
  logic [15:0] ra;

  assign do_wr = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  assign wa = 16'(awaddr_ff);
  assign wbase = {wa[15:4], 4'h0};
  assign walias = {wa[3:2], 2'b00};
  assign wval = {wstrb_ff[1] ? wdata_ff[15:8] : 8'h00, wstrb_ff[0] ? wdata_ff[7:0] : 8'h00};
  assign ra = 16'(s_axi_araddr);
  assign rbase = {ra[15:4], 4'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dst_pkg::DST_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wbase inside {dst_pkg::DST_A_CTRL_OFS, dst_pkg::DST_A_CNT_OFS,
            dst_pkg::DST_A_PER_OFS, dst_pkg::DST_B_CTRL_OFS, dst_pkg::DST_B_CNT_OFS,
            dst_pkg::DST_B_PER_OFS, dst_pkg::DST_STAT_OFS}) ? dst_pkg::DST_RESP_OKAY
            : dst_pkg::DST_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
      end
    end
  end

  // (RL6) alias write: plain, clear, set, invert
  function automatic logic [15:0] apply_alias(input logic [15:0] cur, input logic [15:0] v,
      input logic [3:0] al, input logic [15:0] msk);
    logic [15:0] r;
    r = v;
    unique case (al)
      dst_pkg::DST_ALIAS_CLR: r = cur & ~v;
      dst_pkg::DST_ALIAS_SET: r = cur | v;
      dst_pkg::DST_ALIAS_INV: r = cur ^ v;
      default: r = v;
    endcase
    return r & msk;
  endfunction : apply_alias

  // read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dst_pkg::DST_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= dst_pkg::DST_RESP_OKAY;
        // (RL17) upper half reads zero
        unique case (rbase)
          dst_pkg::DST_A_CTRL_OFS: s_axi_rdata <= {16'h0000, ctrl_ff[0]};
          dst_pkg::DST_A_CNT_OFS: s_axi_rdata <= {16'h0000, cnt_ff[0]};
          dst_pkg::DST_A_PER_OFS: s_axi_rdata <= {16'h0000, per_ff[0]};
          dst_pkg::DST_B_CTRL_OFS: s_axi_rdata <= {16'h0000, ctrl_ff[1]};
          dst_pkg::DST_B_CNT_OFS: s_axi_rdata <= {16'h0000, cnt_ff[1]};
          dst_pkg::DST_B_PER_OFS: s_axi_rdata <= {16'h0000, per_ff[1]};
          dst_pkg::DST_STAT_OFS: s_axi_rdata <= {30'h0, flag_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= dst_pkg::DST_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-timer datapath
  // ----------------------------------------------------------------
  assign cnt32 = {cnt_ff[1], cnt_ff[0]};
  assign per32 = {per_ff[1], per_ff[0]};
  // one shared incrementer feeds both halves in wide mode
  assign cnt32_inc = cnt32 + 32'h0000_0001;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      localparam logic [15:0] CTRL_OFS = g == 0 ? dst_pkg::DST_A_CTRL_OFS
          : dst_pkg::DST_B_CTRL_OFS;
      localparam logic [15:0] CNT_OFS = g == 0 ? dst_pkg::DST_A_CNT_OFS
          : dst_pkg::DST_B_CNT_OFS;
      localparam logic [15:0] PER_OFS = g == 0 ? dst_pkg::DST_A_PER_OFS
          : dst_pkg::DST_B_PER_OFS;
      // (RL16) timer B has no wide select bit
      localparam logic [15:0] MSK = g == 0 ? dst_pkg::DST_CTRL_A_MASK
          : dst_pkg::DST_CTRL_B_MASK;
      logic [15:0] cs;
      logic [15:0] nxt_ctrl;
      logic run, src, en_in, pre_hit;
      logic [2:0] ps;
      logic [7:0] ps_lim;

      // (RL13) wide mode takes every setting from timer A
      assign cs = wide ? ctrl_ff[0] : ctrl_ff[g];
      assign ps = cs[dst_pkg::DST_PS_LSB +: 3];
      // (RL10) ratios 1,2,4,8,16,32,64,256
      assign ps_lim = ps == 3'h7 ? 8'hff : 8'((9'h001 << ps) - 9'h001);
      // (RL7) (RL8) enable and stop-in-idle
      assign run = cs[dst_pkg::DST_ON_BIT] && !(cs[dst_pkg::DST_STOP_IN_IDLE_BIT] && idle_s2_ff);
      // (RL1) (RL11) (RL12) source and gate selection
      assign src = cs[dst_pkg::DST_CS_BIT];
      assign en_in = src ? (ext_s2_ff[g] && !ext_s3_ff[g])
          : (!cs[dst_pkg::DST_GATE_BIT] || gate_s2_ff[g]);
      assign pre_hit = run && en_in && pre_ff[g] == ps_lim;
      assign tick[g] = pre_hit;

      always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
          pre_ff[g] <= 8'h00;
        end else if (en_in) begin
          pre_ff[g] <= pre_hit ? 8'h00 : pre_ff[g] + 8'h01;
        end
      end

      // (RL9) gate bit is dropped when external clock is chosen in timer A; timer B keeps it
      always_comb begin
        nxt_ctrl = apply_alias(ctrl_ff[g], wval, walias, MSK);
        if (nxt_ctrl[dst_pkg::DST_CS_BIT] && g == 0) begin
          nxt_ctrl[dst_pkg::DST_GATE_BIT] = 1'b0;
        end
      end

      // (RL18) reset values
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_ff[g] <= dst_pkg::DST_CTRL_RST;
          per_ff[g] <= dst_pkg::DST_PER_RST;
        end else if (do_wr && wbase == CTRL_OFS) begin
          ctrl_ff[g] <= nxt_ctrl;
        end else if (do_wr && wbase == PER_OFS) begin
          per_ff[g] <= apply_alias(per_ff[g], wval, walias, 16'hffff);
        end
      end

      // (RL19) count and wrap at period
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_ff[g] <= dst_pkg::DST_CNT_RST;
        end else if (do_wr && wbase == CNT_OFS) begin
          cnt_ff[g] <= apply_alias(cnt_ff[g], wval, walias, 16'hffff);
        end else if (wide) begin
          // (RL2) 32-bit count driven by timer A's tick
          if (tick[0]) begin
            if (cnt32 == per32) begin
              cnt_ff[g] <= 16'h0000;
            end else begin
              cnt_ff[g] <= g == 0 ? cnt32_inc[15:0] : cnt32_inc[31:16];
            end
          end
        end else if (tick[g]) begin
          cnt_ff[g] <= cnt_ff[g] == per_ff[g] ? 16'h0000 : cnt_ff[g] + 16'h0001;
        end
      end
    end
  endgenerate

  assign wrap[0] = !wide && tick[0] && cnt_ff[0] == per_ff[0];
  assign wrap[1] = wide ? (tick[0] && cnt32 == per32) : (tick[1] && cnt_ff[1] == per_ff[1]);

  // (RL3) wide wrap reports on timer B flag; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= 2'b00;
    end else begin
      flag_ff <= (do_wr && wbase == dst_pkg::DST_STAT_OFS ? flag_ff & ~wval[1:0] : flag_ff)
          | wrap;
    end
  end

  // (RL4) converter trigger from timer B only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_trig_ff <= 1'b0;
    end else begin
      adc_trig_ff <= wrap[1];
    end
  end

  assign timer_a_flag = flag_ff[0];
  assign timer_b_flag = flag_ff[1];
  assign adc_trigger = adc_trig_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_wrap_zero;
    @(posedge aclk) disable iff (!aresetn)
    (wrap[0] && !(do_wr && wbase == dst_pkg::DST_A_CNT_OFS)) |=> cnt_ff[0] == 16'h0000;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("count not zero after wrap"); // RL19

  property p_flag_b;
    @(posedge aclk) disable iff (!aresetn) wrap[1] |=> timer_b_flag && adc_trigger;
  endproperty
  a_flag_b: assert property (p_flag_b) else $error("timer b flag or trigger missing"); // RL4

  property p_wide_a_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (wide && !(do_wr && wbase == dst_pkg::DST_STAT_OFS)) |=> $stable(timer_a_flag);
  endproperty
  a_wide_a_quiet: assert property (p_wide_a_quiet) else $error("timer a wrapped in wide"); // RL3

  property p_off_hold;
    @(posedge aclk) disable iff (!aresetn)
    (!ctrl_ff[0][dst_pkg::DST_ON_BIT] && !do_wr) |=> $stable(cnt_ff[0]);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("disabled timer counted"); // RL7

  property p_idle_stop;
    @(posedge aclk) disable iff (!aresetn)
    (idle_s2_ff && ctrl_ff[1][dst_pkg::DST_STOP_IN_IDLE_BIT] && !wide) |-> !tick[1];
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("tick during idle stop"); // RL8

  property p_b_bit3;
    @(posedge aclk) disable iff (!aresetn) ctrl_ff[1][dst_pkg::DST_WIDE_BIT] == 1'b0;
  endproperty
  a_b_bit3: assert property (p_b_bit3) else $error("timer b bit 3 set"); // RL16

  property p_gate_ext;
    @(posedge aclk) disable iff (!aresetn)
    ctrl_ff[0][dst_pkg::DST_CS_BIT] |-> !ctrl_ff[0][dst_pkg::DST_GATE_BIT];
  endproperty
  a_gate_ext: assert property (p_gate_ext) else $error("gate bit set with external"); // RL9

  property p_prescale;
    @(posedge aclk) disable iff (!aresetn)
    (tick[1] && !wide && ctrl_ff[1][dst_pkg::DST_PS_LSB +: 3] == 3'h1
        && !ctrl_ff[1][dst_pkg::DST_CS_BIT] && !ctrl_ff[1][dst_pkg::DST_GATE_BIT])
        |=> !tick[1];
  endproperty
  a_prescale: assert property (p_prescale) else $error("divide by two ticked twice"); // RL10

  property p_trig_b_only;
    @(posedge aclk) disable iff (!aresetn) !wrap[1] |=> !adc_trigger;
  endproperty
  a_trig_b_only: assert property (p_trig_b_only) else $error("trigger without b wrap"); // RL4

  property p_gate_low;
    @(posedge aclk) disable iff (!aresetn)
    (!wide && !ctrl_ff[1][dst_pkg::DST_CS_BIT] && ctrl_ff[1][dst_pkg::DST_GATE_BIT]
        && !gate_s2_ff[1]) |-> !tick[1];
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("tick with gate low"); // RL20

  property p_reset_per;
    @(posedge aclk) !aresetn |=> per_ff[0] == 16'hffff && cnt_ff[0] == 16'h0000;
  endproperty
  a_reset_per: assert property (p_reset_per) else $error("bad reset value"); // RL18

  c_wrap_a: cover property (@(posedge aclk) disable iff (!aresetn) wrap[0]);
  c_wide_wrap: cover property (@(posedge aclk) disable iff (!aresetn) wide && wrap[1]);
  c_ext_tick: cover property (@(posedge aclk) disable iff (!aresetn)
      tick[1] && ctrl_ff[1][dst_pkg::DST_CS_BIT]);
  c_gate_tick: cover property (@(posedge aclk) disable iff (!aresetn)
      tick[1] && ctrl_ff[1][dst_pkg::DST_GATE_BIT] && !wide);
  c_idle_hold: cover property (@(posedge aclk) disable iff (!aresetn)
      idle_s2_ff && ctrl_ff[1][dst_pkg::DST_STOP_IN_IDLE_BIT] && ctrl_ff[1][dst_pkg::DST_ON_BIT]);

endmodule : dst_timer_pair

/* File: sim/dst_timer_pair_tb.sv */
// self-checking testbench for the dual synchronous timer pair
`timescale 1ns/10ps
module dst_timer_pair_tb;
  localparam logic [15:0] AC = dst_pkg::DST_A_CTRL_OFS;
  localparam logic [15:0] AN = dst_pkg::DST_A_CNT_OFS;
  localparam logic [15:0] AP = dst_pkg::DST_A_PER_OFS;
  localparam logic [15:0] BC = dst_pkg::DST_B_CTRL_OFS;
  localparam logic [15:0] BN = dst_pkg::DST_B_CNT_OFS;
  localparam logic [15:0] BP = dst_pkg::DST_B_PER_OFS;
  localparam logic [15:0] ST = dst_pkg::DST_STAT_OFS;
  localparam logic [1:0] OK = dst_pkg::DST_RESP_OKAY;
  localparam int LIMIT = 30000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, idle_mode = 1'b0;
  logic ext_a = 1'b0, ext_b = 1'b0, gate_a = 1'b0, gate_b = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic timer_a_flag, timer_b_flag, adc_trigger;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n_trig = 0;

  always #4 aclk = ~aclk;

  dst_timer_pair u_dst_timer_pair (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .idle_mode(idle_mode),
    .timer_a_ext_clock_pin(ext_a), .timer_b_ext_clock_pin(ext_b),
    .timer_a_gate_pin(gate_a), .timer_b_gate_pin(gate_b), .timer_a_flag(timer_a_flag),
    .timer_b_flag(timer_b_flag), .adc_trigger(adc_trigger));

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (adc_trigger === 1'b1) n_trig <= n_trig + 1;
    if (cycles == LIMIT) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e = OK);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, e});
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d, input logic [1:0] e = OK);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, e});
  endtask : rd

  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rchk

  // cycles between two successive converter trigger pulses
  task automatic gap(output int n);
    do @(posedge aclk); while (adc_trigger !== 1'b1);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (adc_trigger !== 1'b1);
  endtask : gap

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_bits();
    logic [15:0] regs [6];
    logic [31:0] d;
    regs = '{AC, AN, AP, BC, BN, BP};
    foreach (regs[i]) rchk(regs[i], (i % 3 == 2) ? 32'h0000_ffff : 32'h0);
    wr(BC, 32'hffff_fffd);
    rchk(BC, 32'h0000_a0f0);
    wr(AC, 32'hffff_ffff);
    rchk(AC, 32'h0000_a07a);
    wr(AC, 32'h0);
    wr(BC, 32'h0);
    rd(16'h8100, d, dst_pkg::DST_RESP_SLVERR);
    chk(d, 32'h0);
    wr(16'h8104, 32'h1, dst_pkg::DST_RESP_SLVERR);
  endtask : t_reset_and_bits

  task automatic t_alias();
    wr(AN, 32'h0000_1234);
    wr(AN + 16'h8, 32'h0000_00f0);
    rchk(AN, 32'h0000_12f4);
    wr(AN + 16'h4, 32'h0000_0204);
    rchk(AN, 32'h0000_10f0);
    wr(AN + 16'hc, 32'hffff_ffff);
    rchk(AN, 32'h0000_ef0f);
  endtask : t_alias

  task automatic t_prescale();
    int div [8];
    int n;
    div = '{1, 2, 4, 8, 16, 32, 64, 256};
    wr(BP, 32'h3);
    for (int k = 0; k < 8; k++) begin
      wr(BC, 32'h8000 | (k << 4));
      gap(n);
      chk(32'(n), 32'(4 * div[k]));
    end
    chk({31'h0, timer_b_flag}, 32'h1);
    wr(BC, 32'h0);
    wr(ST, 32'h3);
  endtask : t_prescale

  task automatic t_a_only();
    int t0;
    t0 = n_trig;
    wr(AN, 32'h0);
    wr(AP, 32'h3);
    wr(AC, 32'h8000);
    repeat (40) @(posedge aclk);
    wr(AC, 32'h0);
    chk({31'h0, timer_a_flag}, 32'h1);
    chk(32'(n_trig), 32'(t0));
    wr(ST, 32'h1);
    chk({30'h0, timer_b_flag, timer_a_flag}, 32'h0);
  endtask : t_a_only

  // two reads apart; same value means the count stands still
  task automatic t_moves(input logic [15:0] a, input logic [31:0] moving);
    logic [31:0] c1, c2;
    repeat (4) @(posedge aclk);
    rd(a, c1);
    repeat (6) @(posedge aclk);
    rd(a, c2);
    chk({31'h0, c1 !== c2}, moving);
  endtask : t_moves

  task automatic t_idle_gate();
    wr(BP, 32'hffff);
    idle_mode <= 1'b1;
    wr(BC, 32'ha000);
    t_moves(BN, 32'h0);
    wr(BC, 32'h8000);
    t_moves(BN, 32'h1);
    idle_mode <= 1'b0;
    wr(BC, 32'h8080);
    t_moves(BN, 32'h0);
    gate_b <= 1'b1;
    t_moves(BN, 32'h1);
    gate_b <= 1'b0;
    wr(BC, 32'h0);
  endtask : t_idle_gate

  task automatic t_ext(input bit use_b);
    logic [15:0] c;
    logic [15:0] n;
    logic [15:0] p;
    c = use_b ? BC : AC;
    n = use_b ? BN : AN;
    p = use_b ? BP : AP;
    wr(c, 32'h0);
    wr(p, 32'hffff);
    wr(n, 32'h0);
    wr(c, 32'h8002);
    repeat (5) begin
      if (use_b) ext_b <= 1'b1;
      else ext_a <= 1'b1;
      repeat (4) @(posedge aclk);
      if (use_b) ext_b <= 1'b0;
      else ext_a <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
    rchk(n, 32'h5);
    wr(c, 32'h0);
  endtask : t_ext

  task automatic t_wide();
    int n;
    wr(ST, 32'h3);
    wr(AP, 32'h3);
    wr(BP, 32'h0);
    wr(AN, 32'h0);
    wr(BN, 32'h0);
    wr(BC, 32'h0072);
    wr(AC, 32'h8008);
    gap(n);
    chk(32'(n), 32'h4);
    chk({30'h0, timer_b_flag, timer_a_flag}, 32'h2);
    wr(AC, 32'h0);
  endtask : t_wide

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_and_bits();
    t_alias();
    t_prescale();
    t_a_only();
    t_idle_gate();
    t_ext(1'b0);
    t_ext(1'b1);
    t_wide();
    complete_run();
  end
endmodule : dst_timer_pair_tb
